// ---- rtl/sbp_pkg.sv ----
// Shared constants, carrier types and the byte merge for the burst SRAM port.
// Assumes a 10 MHz core clock that samples the master clocks as ordinary inputs.
package sbp_pkg;
   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int WORD_W = 36;
   localparam int BYTE_W = 9;
   localparam int NBYTES = 4;
   localparam int BURST = 4;
   localparam int ADDR_W_DEF = 18;
   // ----------------------------------------------------------------
   // Half-edge positions of the burst pipelines
   // ----------------------------------------------------------------
   localparam int RD_POS_PLL = 5;
   localparam int RD_POS_LEGACY = 3;
   localparam int WR_POS = 2;
   localparam int RD_LINE = RD_POS_PLL + BURST;
   localparam int WR_LINE = WR_POS + BURST;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int LOCK_TIME_US = 20;
   localparam int LOCK_CYC = (LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STOP_TIME_NS = 30;
   localparam int STOP_CYC_RAW = (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STOP_CYC = (STOP_CYC_RAW < 1) ? 1 : STOP_CYC_RAW;
   localparam int IMP_PERIOD = 1024;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic OE_N_RST = 1'h1;
   localparam logic [NBYTES-1:0] BE_N_RST = 4'hF;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_NONE = 2'b00,
      OP_READ = 2'b01,
      OP_WRITE = 2'b10
   } sbp_op_e;
   typedef struct packed {
      logic v;
      logic slot;
   } sbp_tok_s;
   typedef struct packed {
      logic [WORD_W-1:0] data;
      logic [NBYTES-1:0] be_n;
   } sbp_wword_s;
   // Replaces each byte whose active-low select is asserted.
   function automatic logic [WORD_W-1:0] sbp_merge(input logic [WORD_W-1:0] old_w,
                                                    input logic [WORD_W-1:0] new_w,
                                                    input logic [NBYTES-1:0] be_n);
      logic [WORD_W-1:0] r;
      r = old_w;
      for (int b = 0; b < NBYTES; b++) begin
         if (!be_n[b]) begin
            r[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
         end
      end
      return r;
   endfunction : sbp_merge
endpackage : sbp_pkg

// ---- rtl/sbp_sram_port.sv ----
// Burst SRAM front end with separate read and write ports and a shared address.
// Assumes the master clocks, selects, address and data come from outside the core clock domain.
//
// Operation
// RQ1: PLL enabled: first read word two master cycles after the request; code drives it on the fifth half edge, 2.5 cycles.
// RQ2: PLL disabled: legacy mode, read latency one master cycle; code drives the first word on the third half edge, 1.5 cycles.
// RQ3: Port selects sampled only on positive master clock rise; accesses start there.
// RQ4: Bursts of four 36-bit words; read address captured with the request.
// RQ5: Lowest word out on negative edge, then one word each following edge.
// RQ6: Reads spaced two rises apart; an immediate second read is ignored.
// RQ7: Deselected read port finishes bursts then tri-states after next negative rise.
// RQ8: Write words captured on next positive rise, following edges, four in all.
// RQ9: All four collected words written together at the captured address.
// RQ10: Writes spaced two rises apart; an immediate second write is ignored.
// RQ11: Deselected write port completes its burst and ignores write inputs.
// RQ12: Active-low byte selects sampled per word; deasserted bytes stay unchanged.
// RQ13: Select n governs bits 9n+8 down to 9n of each word.
// RQ14: Read after write to same address returns newest data by forwarding.
// RQ15: Both selected: read wins after idle or write, write wins after read.
// RQ16: Holding both selects from idle alternates read and write, read first.
// RQ17: Ports independent; pending accesses finish before counting as deselected.
// RQ18: Output impedance recalibrated once every 1024 master clock cycles.
// RQ19: Free-running true and complement echo clocks follow the master clocks.
// RQ20: Read-valid asserted half a cycle before data, aligned like data.
// RQ21: PLL counts as locked 20 us after a stable clock.
// RQ22: Stopping both master clocks at least 30 ns resets the PLL.
// RQ23: Controller runs PLL mode only from 120 MHz to rated maximum; the bench controller model runs PLL mode with an 800 ns master clock period.
// RQ24: Powers up with both ports deselected and outputs tri-stated.
// RQ25: Read and write acceptance held off until the lock interval elapses.
`timescale 1ns/1ps
module sbp_sram_port #(
   parameter int ADDR_W = sbp_pkg::ADDR_W_DEF,
   parameter int LOCK_CYC = sbp_pkg::LOCK_CYC,
   parameter int IMP_PERIOD = sbp_pkg::IMP_PERIOD
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic master_clk,
   input wire logic master_clk_n,
   input wire logic pll_disable_n,
   input wire logic read_port_select_n,
   input wire logic write_port_select_n,
   input wire logic [ADDR_W-1:0] address,
   input wire logic [sbp_pkg::WORD_W-1:0] write_data,
   input wire logic [sbp_pkg::NBYTES-1:0] byte_write_select_n,
   output logic [sbp_pkg::WORD_W-1:0] read_data,
   output logic read_data_oe_n,
   output logic read_valid_flag,
   output logic echo_timing_true,
   output logic echo_timing_comp,
   output logic impedance_update,
   output logic pll_locked
);
   localparam int SW = ADDR_W + sbp_pkg::WORD_W + sbp_pkg::NBYTES + 5;
   localparam int DEPTH = 1 << ADDR_W;
   // ----------------------------------------------------------------
   // Input synchronisers and edge detection
   // ----------------------------------------------------------------
   logic [SW-1:0] sync1_ff;
   logic [SW-1:0] sync2_ff;
   logic k_prev_ff;
   logic kn_prev_ff;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         k_prev_ff <= 1'h0;
         kn_prev_ff <= 1'h0;
      end else begin
         sync1_ff <= {master_clk, master_clk_n, pll_disable_n, read_port_select_n, write_port_select_n,
                      byte_write_select_n, write_data, address};
         sync2_ff <= sync1_ff;
         k_prev_ff <= sync2_ff[SW-1];
         kn_prev_ff <= sync2_ff[SW-2];
      end
   end
   logic k_s, kn_s, pll_on, rsel, wsel;
   logic [sbp_pkg::NBYTES-1:0] be_n_s;
   logic [sbp_pkg::WORD_W-1:0] d_s;
   logic [ADDR_W-1:0] addr_s;
   logic k_rise, kn_rise, hedge;
   assign {k_s, kn_s, pll_on} = sync2_ff[SW-1 -: 3];
   assign rsel = !sync2_ff[SW-4];
   assign wsel = !sync2_ff[SW-5];
   assign {be_n_s, d_s, addr_s} = sync2_ff[SW-6:0];
   assign k_rise = k_s && !k_prev_ff;
   assign kn_rise = kn_s && !kn_prev_ff;
   assign hedge = k_rise || kn_rise;
   // ----------------------------------------------------------------
   // Lock interval and clock-stop detection
   // ----------------------------------------------------------------
   logic [7:0] same_cnt_ff;
   logic [15:0] lock_cnt_ff;
   logic stopped, locked;
   assign stopped = same_cnt_ff >= 8'(sbp_pkg::STOP_CYC);
   assign locked = !pll_on || (lock_cnt_ff == 16'(LOCK_CYC));
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         same_cnt_ff <= '0;
         lock_cnt_ff <= '0;
      end else begin
         if (k_s != kn_s) begin
            same_cnt_ff <= '0;
         end else if (!stopped) begin
            same_cnt_ff <= same_cnt_ff + 8'h01;
         end
         if (stopped) begin
            lock_cnt_ff <= '0; // RQ22
         end else if (lock_cnt_ff != 16'(LOCK_CYC)) begin
            lock_cnt_ff <= lock_cnt_ff + 16'h0001; // RQ21
         end
      end
   end
   // ----------------------------------------------------------------
   // Request acceptance and arbitration
   // ----------------------------------------------------------------
   sbp_pkg::sbp_op_e last_op_ff;
   logic rd_last, wr_last, take_rd, take_wr;
   always_comb begin
      rd_last = 1'h0;
      wr_last = 1'h0;
      case (last_op_ff)
         sbp_pkg::OP_READ: rd_last = 1'h1;
         sbp_pkg::OP_WRITE: wr_last = 1'h1;
         sbp_pkg::OP_NONE: rd_last = 1'h0;
         default: rd_last = 1'h0;
      endcase
   end
   assign take_rd = k_rise && locked && rsel && !rd_last; // RQ3 RQ6 RQ15 RQ25
   assign take_wr = k_rise && locked && wsel && !wr_last && !take_rd; // RQ3 RQ10 RQ15 RQ16 RQ25
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         last_op_ff <= sbp_pkg::OP_NONE; // RQ24
      end else if (k_rise) begin
         last_op_ff <= take_rd ? sbp_pkg::OP_READ : (take_wr ? sbp_pkg::OP_WRITE : sbp_pkg::OP_NONE);
      end
   end
   // ----------------------------------------------------------------
   // Half-edge pipelines for both ports
   // ----------------------------------------------------------------
   sbp_pkg::sbp_tok_s rline_ff [sbp_pkg::RD_LINE];
   sbp_pkg::sbp_tok_s wline_ff [sbp_pkg::WR_LINE];
   sbp_pkg::sbp_tok_s nxt_rline [sbp_pkg::RD_LINE];
   sbp_pkg::sbp_tok_s nxt_wline [sbp_pkg::WR_LINE];
   logic rslot_ff, wslot_ff;
   logic [ADDR_W-1:0] raddr_ff [2];
   logic [ADDR_W-1:0] waddr_ff [2];
   always_comb begin
      nxt_rline[0] = '{v: take_rd, slot: rslot_ff};
      nxt_wline[0] = '{v: take_wr, slot: wslot_ff};
      for (int i = 1; i < sbp_pkg::RD_LINE; i++) begin
         nxt_rline[i] = rline_ff[i-1];
      end
      for (int i = 1; i < sbp_pkg::WR_LINE; i++) begin
         nxt_wline[i] = wline_ff[i-1];
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rline_ff <= '{default: '0};
         wline_ff <= '{default: '0};
         rslot_ff <= 1'h0;
         wslot_ff <= 1'h0;
         raddr_ff <= '{default: '0};
         waddr_ff <= '{default: '0};
      end else begin
         if (hedge) begin
            rline_ff <= nxt_rline;
            wline_ff <= nxt_wline;
         end
         if (take_rd) begin
            raddr_ff[rslot_ff] <= addr_s; // RQ4
            rslot_ff <= !rslot_ff;
         end
         if (take_wr) begin
            waddr_ff[wslot_ff] <= addr_s;
            wslot_ff <= !wslot_ff;
         end
      end
   end
   // ----------------------------------------------------------------
   // Write collection and commit
   // ----------------------------------------------------------------
   logic [sbp_pkg::WORD_W-1:0] mem_ff [DEPTH][sbp_pkg::BURST];
   sbp_pkg::sbp_wword_s wbuf_ff [sbp_pkg::BURST];
   logic wr_pend_ff, wc_slot_ff;
   logic wcol_v, commit;
   logic [1:0] wcol_idx;
   logic wcol_slot;
   always_comb begin
      wcol_v = 1'h0;
      wcol_idx = 2'h0;
      wcol_slot = 1'h0;
      for (int i = 0; i < sbp_pkg::BURST; i++) begin
         if (hedge && nxt_wline[sbp_pkg::WR_POS+i].v) begin
            wcol_v = 1'h1; // RQ8 RQ11
            wcol_idx = 2'(i);
            wcol_slot = nxt_wline[sbp_pkg::WR_POS+i].slot;
         end
      end
   end
   assign commit = wcol_v && (wcol_idx == 2'(sbp_pkg::BURST - 1));
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wbuf_ff <= '{default: '{data: '0, be_n: sbp_pkg::BE_N_RST}};
         wr_pend_ff <= 1'h0;
         wc_slot_ff <= 1'h0;
      end else if (commit) begin
         wbuf_ff <= '{default: '{data: '0, be_n: sbp_pkg::BE_N_RST}};
         wr_pend_ff <= 1'h0;
      end else if (wcol_v) begin
         wbuf_ff[wcol_idx] <= '{data: d_s, be_n: be_n_s}; // RQ12
         wr_pend_ff <= 1'h1;
         wc_slot_ff <= wcol_slot;
      end
   end
   // Storage carries no reset; only the control around it does.
   always_ff @(posedge clock) begin
      if (commit) begin
         for (int i = 0; i < sbp_pkg::BURST - 1; i++) begin
            mem_ff[waddr_ff[wcol_slot]][i] <= sbp_pkg::sbp_merge(mem_ff[waddr_ff[wcol_slot]][i],
                                                                 wbuf_ff[i].data, wbuf_ff[i].be_n); // RQ9 RQ13
         end
         mem_ff[waddr_ff[wcol_slot]][sbp_pkg::BURST-1] <=
            sbp_pkg::sbp_merge(mem_ff[waddr_ff[wcol_slot]][sbp_pkg::BURST-1], d_s, be_n_s); // RQ9 RQ12
      end
   end
   // ----------------------------------------------------------------
   // Read emission, valid flag and output enable
   // ----------------------------------------------------------------
   int pos;
   logic emit_v, emit_slot, valid_nxt, fwd_hit;
   logic [1:0] emit_idx;
   logic [ADDR_W-1:0] emit_addr;
   logic [sbp_pkg::WORD_W-1:0] emit_word;
   always_comb begin
      pos = pll_on ? sbp_pkg::RD_POS_PLL : sbp_pkg::RD_POS_LEGACY; // RQ1 RQ2
      emit_v = 1'h0;
      emit_slot = 1'h0;
      emit_idx = 2'h0;
      valid_nxt = 1'h0;
      for (int i = 0; i < sbp_pkg::BURST; i++) begin
         if (nxt_rline[pos+i].v) begin
            emit_v = 1'h1; // RQ5
            emit_idx = 2'(i);
            emit_slot = nxt_rline[pos+i].slot;
         end
         if (nxt_rline[pos-1+i].v) begin
            valid_nxt = 1'h1; // RQ20
         end
      end
      emit_addr = raddr_ff[emit_slot];
      fwd_hit = wr_pend_ff && (waddr_ff[wc_slot_ff] == emit_addr);
      emit_word = mem_ff[emit_addr][emit_idx];
      if (fwd_hit) begin
         emit_word = sbp_pkg::sbp_merge(emit_word, wbuf_ff[emit_idx].data, wbuf_ff[emit_idx].be_n); // RQ14
      end
   end
   logic [sbp_pkg::WORD_W-1:0] q_ff;
   logic q_oe_n_ff, valid_ff;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         q_ff <= '0;
         q_oe_n_ff <= sbp_pkg::OE_N_RST; // RQ24
         valid_ff <= 1'h0;
      end else if (hedge) begin
         q_ff <= emit_v ? emit_word : '0;
         q_oe_n_ff <= !emit_v; // RQ7 RQ17
         valid_ff <= valid_nxt; // RQ20
      end
   end
   // ----------------------------------------------------------------
   // Echo clocks, impedance update and lock status
   // ----------------------------------------------------------------
   logic echo_t_ff, echo_c_ff, imp_ff, locked_ff;
   logic [15:0] imp_cnt_ff;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         echo_t_ff <= 1'h0;
         echo_c_ff <= 1'h0;
         imp_ff <= 1'h0;
         imp_cnt_ff <= '0;
         locked_ff <= 1'h0;
      end else begin
         echo_t_ff <= k_s; // RQ19
         echo_c_ff <= kn_s; // RQ19
         locked_ff <= locked;
         imp_ff <= 1'h0;
         if (k_rise) begin
            if (imp_cnt_ff == 16'(IMP_PERIOD - 1)) begin
               imp_cnt_ff <= '0;
               imp_ff <= 1'h1; // RQ18
            end else begin
               imp_cnt_ff <= imp_cnt_ff + 16'h0001;
            end
         end
      end
   end
   assign read_data = q_ff;
   assign read_data_oe_n = q_oe_n_ff;
   assign read_valid_flag = valid_ff;
   assign echo_timing_true = echo_t_ff;
   assign echo_timing_comp = echo_c_ff;
   assign impedance_update = imp_ff;
   assign pll_locked = locked_ff;
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   pll_latency_a: assert property (hedge && pll_on && nxt_rline[sbp_pkg::RD_POS_PLL].v |=> !q_oe_n_ff) // RQ1
      else $error("read word not driven at PLL latency");
   legacy_latency_a: assert property (hedge && !pll_on && nxt_rline[sbp_pkg::RD_POS_LEGACY].v |=> !q_oe_n_ff) // RQ2
      else $error("read word not driven at legacy latency");
   read_spacing_a: assert property (k_rise && rline_ff[1].v |-> !take_rd) // RQ6
      else $error("consecutive read accepted");
   write_spacing_a: assert property (k_rise && wline_ff[1].v |-> !take_wr) // RQ10
      else $error("consecutive write accepted");
   arb_idle_read_a: assert property (k_rise && locked && rsel && wsel && !rd_last |-> take_rd && !take_wr) // RQ15
      else $error("read did not win arbitration");
   arb_after_read_a: assert property (k_rise && locked && rsel && wsel && rd_last |-> take_wr) // RQ16
      else $error("write did not follow read");
   lock_holdoff_a: assert property (!locked |-> !take_rd && !take_wr) // RQ25
      else $error("request accepted before lock");
   stop_relock_a: assert property (pll_on && stopped |-> ##2 !locked_ff) // RQ22
      else $error("lock survived stopped clocks");
   valid_lead_a: assert property ($rose(valid_ff) |-> q_oe_n_ff) // RQ20
      else $error("valid flag did not lead data");
   idle_tristate_a: assert property (hedge && !emit_v |=> q_oe_n_ff) // RQ7
      else $error("outputs driven with no pending read");
   impedance_pulse_a: assert property (imp_ff |=> !imp_ff) // RQ18
      else $error("impedance update longer than one cycle");
   cov_read_c: cover property (take_rd ##[1:100] !q_oe_n_ff);
   cov_write_c: cover property (commit);
   cov_alt_c: cover property (take_rd ##[1:20] take_wr);
   cov_fwd_c: cover property (hedge && emit_v && fwd_hit);
endmodule : sbp_sram_port

// ---- sim/sbp_ctrl_model.sv ----
// Memory controller model: free-running master clocks and a scheduled request stream.
// Assumes the bench core clock; the bench fills the schedule arrays before calling start.
`timescale 1ns/1ps
module sbp_ctrl_model #(
   parameter int ADDR_W = 4
) (
   input wire logic clock,
   output logic master_clk,
   output logic master_clk_n,
   output logic read_port_select_n,
   output logic write_port_select_n,
   output logic [ADDR_W-1:0] address,
   output logic [sbp_pkg::WORD_W-1:0] write_data,
   output logic [sbp_pkg::NBYTES-1:0] byte_write_select_n
);
   // ----------------------------------------------------------------
   // Schedule and pins
   // ----------------------------------------------------------------
   logic rd_n [16];
   logic wr_n [16];
   logic [ADDR_W-1:0] ad [16];
   logic [sbp_pkg::WORD_W-1:0] wd [36];
   logic [sbp_pkg::NBYTES-1:0] be_n [36];
   logic stop = 1'b0;
   int ph = 0;
   int idx = 0;
   int n_act = 0;
   int n_pend = 0;
   realtime t_rise0 = 0;
   task automatic start(input int n);
      n_pend = n;
   endtask : start
   function automatic logic busy();
      return n_pend > 0 || idx < n_act + 2;
   endfunction : busy
   initial begin
      master_clk = 1'b0;
      master_clk_n = 1'b1;
      read_port_select_n = 1'b1;
      write_port_select_n = 1'b1;
      address = '0;
      write_data = '0;
      byte_write_select_n = 4'hf;
   end
   // Inputs change three core cycles after a master edge, so each is stable around the edge that takes it.
   always @(posedge clock) begin
      ph = (ph + 1) % 8;
      master_clk <= stop | (ph < 4);
      master_clk_n <= stop | (ph >= 4);
      if (ph == 7 && n_pend > 0) begin
         n_act = n_pend;
         n_pend = 0;
         idx = 0;
      end
      if (ph == 0 && idx == 0 && n_act > 0) begin
         t_rise0 = $realtime;
      end
      if (ph == 7 || ph == 3) begin
         if (ph == 7 && idx < n_act) begin
            read_port_select_n <= rd_n[idx];
            write_port_select_n <= wr_n[idx];
            address <= ad[idx];
         end else begin
            read_port_select_n <= 1'b1;
            write_port_select_n <= 1'b1;
            address <= ~address;
         end
         if (idx < n_act + 2) begin
            write_data <= wd[2 * idx + int'(ph == 3)];
            byte_write_select_n <= be_n[2 * idx + int'(ph == 3)];
            if (ph == 3) begin
               idx = idx + 1;
            end
         end else begin
            write_data <= ~write_data;
            byte_write_select_n <= ~byte_write_select_n;
         end
      end
   end
endmodule : sbp_ctrl_model

// ---- sim/tb_top.sv ----
// Self-checking bench for the burst SRAM port driven by the scheduled controller model.
// Assumes the design package; runs with short lock and impedance counts.
`timescale 1ns/1ps
module tb_top;
   localparam int AW = 4;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic pll_disable_n = 1'b1;
   logic master_clk, master_clk_n, read_port_select_n, write_port_select_n;
   logic [AW-1:0] address;
   logic [35:0] write_data, read_data;
   logic [3:0] byte_write_select_n;
   logic read_data_oe_n, read_valid_flag, echo_timing_true, echo_timing_comp, impedance_update, pll_locked;
   int fail_count = 0;
   int checks_done = 0;
   int cyc = 0;
   realtime t_oe = 0;
   realtime t_vld = 0;
   realtime lat = 0;
   logic [35:0] mem [16][4];
   logic [35:0] got [8];
   sbp_ctrl_model #(.ADDR_W(AW)) u_sbp_ctrl_model (.clock(clock), .master_clk(master_clk),
      .master_clk_n(master_clk_n), .read_port_select_n(read_port_select_n),
      .write_port_select_n(write_port_select_n), .address(address), .write_data(write_data),
      .byte_write_select_n(byte_write_select_n));
   sbp_sram_port #(.ADDR_W(AW), .LOCK_CYC(40), .IMP_PERIOD(4)) u_sbp_sram_port (.clock(clock), .rst(rst),
      .master_clk(master_clk), .master_clk_n(master_clk_n), .pll_disable_n(pll_disable_n),
      .read_port_select_n(read_port_select_n), .write_port_select_n(write_port_select_n),
      .address(address), .write_data(write_data), .byte_write_select_n(byte_write_select_n),
      .read_data(read_data), .read_data_oe_n(read_data_oe_n), .read_valid_flag(read_valid_flag),
      .echo_timing_true(echo_timing_true), .echo_timing_comp(echo_timing_comp),
      .impedance_update(impedance_update), .pll_locked(pll_locked));
   initial begin
      forever #50 clock = ~clock;
   end
   always @(negedge read_data_oe_n) t_oe = $realtime;
   always @(posedge read_valid_flag) t_vld = $realtime;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         fail_count++;
         finish_test();
      end
   end
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic finish_test();
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test
   task automatic chk_w(input logic [35:0] g, input logic [35:0] e, input string m);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask : chk_w
   task automatic chk_t(input realtime g, input realtime e, input string m);
      checks_done++;
      if (g != e) begin
         fail_count++;
         $display("unexpected at %0t: %s got %0t want %0t", $time, m, g, e);
      end
   endtask : chk_t
   function automatic logic [35:0] pat(input int a, input int k, input logic [7:0] s);
      return {4'hc, s, a[3:0], k[3:0], ~s, 4'h6, a[3:0]};
   endfunction : pat
   task automatic clr();
      for (int i = 0; i < 16; i++) begin
         u_sbp_ctrl_model.rd_n[i] = 1'b1;
         u_sbp_ctrl_model.wr_n[i] = 1'b1;
         u_sbp_ctrl_model.ad[i] = 4'(i);
      end
      for (int h = 0; h < 36; h++) begin
         u_sbp_ctrl_model.wd[h] = {h[3:0], 32'h5a5a_c3c3};
         u_sbp_ctrl_model.be_n[h] = 4'(h);
      end
   endtask : clr
   task automatic req(input int i, input logic rdn, input logic wrn, input int a);
      u_sbp_ctrl_model.rd_n[i] = rdn;
      u_sbp_ctrl_model.wr_n[i] = wrn;
      u_sbp_ctrl_model.ad[i] = 4'(a);
   endtask : req
   // Words of a write taken at rise i land on half edges 2i+2 to 2i+5; the expected image follows the byte selects.
   task automatic wwords(input int i, input int a, input logic [7:0] s, input logic [15:0] bm);
      logic [35:0] w;
      for (int k = 0; k < 4; k++) begin
         w = pat(a, k, s);
         u_sbp_ctrl_model.wd[2 * i + 2 + k] = w;
         u_sbp_ctrl_model.be_n[2 * i + 2 + k] = bm[4 * k +: 4];
         for (int b = 0; b < 4; b++) begin
            if (!bm[4 * k + b]) mem[a][k][9 * b +: 9] = w[9 * b +: 9];
         end
      end
   endtask : wwords
   task automatic grab(input int nw);
      for (int c = 0; c < 300 && read_data_oe_n !== 1'b0; c++) @(negedge clock);
      for (int k = 0; k < nw; k++) begin
         got[k] = read_data;
         repeat (4) @(negedge clock);
      end
      chk_w({35'h0, read_data_oe_n}, 36'h1, "outputs not released");
   endtask : grab
   task automatic xfer(input int n, input int nw);
      fork
         begin
            u_sbp_ctrl_model.start(n);
            @(posedge clock);
            for (int c = 0; c < 400 && u_sbp_ctrl_model.busy(); c++) @(posedge clock);
            repeat (16) @(posedge clock);
         end
         if (nw > 0) grab(nw);
      join
   endtask : xfer
   task automatic cmp4(input int a, input int base);
      for (int k = 0; k < 4; k++) chk_w(got[base + k], mem[a][k], "read word");
   endtask : cmp4
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_lock();
      repeat (30) @(negedge clock);
      chk_w({35'h0, pll_locked}, 36'h0, "locked early");
      repeat (20) @(negedge clock);
      chk_w({35'h0, pll_locked}, 36'h1, "not locked");
   endtask : t_lock
   task automatic t_write_read();
      clr();
      req(0, 1, 0, 3);
      wwords(0, 3, 8'h11, 16'h0000);
      req(2, 1, 0, 9);
      wwords(2, 9, 8'h22, 16'h0000);
      xfer(3, 0);
      clr();
      req(0, 0, 1, 3);
      req(2, 0, 1, 9);
      xfer(3, 8);
      cmp4(3, 0);
      cmp4(9, 4);
      chk_t(t_oe - t_vld, 400, "valid lead");
      lat = t_oe - u_sbp_ctrl_model.t_rise0;
   endtask : t_write_read
   task automatic t_bytes();
      clr();
      req(0, 1, 0, 3);
      wwords(0, 3, 8'h3c, 16'h7bde);
      xfer(1, 0);
      clr();
      req(0, 0, 1, 3);
      xfer(1, 4);
      cmp4(3, 0);
   endtask : t_bytes
   task automatic t_b2b();
      clr();
      req(0, 1, 0, 5);
      wwords(0, 5, 8'h55, 16'h0000);
      req(1, 1, 0, 9);
      xfer(2, 0);
      clr();
      req(0, 0, 1, 3);
      req(1, 0, 1, 9);
      xfer(2, 4);
      cmp4(3, 0);
      clr();
      req(0, 0, 1, 9);
      req(2, 0, 1, 5);
      xfer(3, 8);
      cmp4(9, 0);
      cmp4(5, 4);
   endtask : t_b2b
   task automatic t_arbit();
      clr();
      req(0, 0, 0, 9);
      req(1, 0, 0, 6);
      req(2, 0, 0, 3);
      req(3, 0, 0, 8);
      wwords(1, 6, 8'h66, 16'h0000);
      wwords(3, 8, 8'h88, 16'h0000);
      xfer(4, 8);
      cmp4(9, 0);
      cmp4(3, 4);
      clr();
      req(0, 0, 1, 6);
      req(2, 0, 1, 8);
      xfer(3, 8);
      cmp4(6, 0);
      cmp4(8, 4);
   endtask : t_arbit
   task automatic t_forward();
      clr();
      req(0, 1, 0, 12);
      wwords(0, 12, 8'hf0, 16'h0000);
      req(1, 0, 1, 12);
      xfer(2, 4);
      cmp4(12, 0);
   endtask : t_forward
   task automatic t_legacy();
      @(posedge clock) pll_disable_n <= 1'b0;
      repeat (16) @(negedge clock);
      chk_w({35'h0, pll_locked}, 36'h1, "legacy lock");
      clr();
      req(0, 0, 1, 3);
      xfer(1, 4);
      cmp4(3, 0);
      chk_t(lat - (t_oe - u_sbp_ctrl_model.t_rise0), 800, "latency step");
      @(posedge clock) pll_disable_n <= 1'b1;
      repeat (60) @(posedge clock);
   endtask : t_legacy
   task automatic t_clkstop();
      realtime tv;
      @(posedge clock) u_sbp_ctrl_model.stop <= 1'b1;
      repeat (16) @(negedge clock);
      chk_w({35'h0, pll_locked}, 36'h0, "lock kept");
      @(posedge clock) u_sbp_ctrl_model.stop <= 1'b0;
      tv = t_oe;
      clr();
      req(0, 0, 1, 3);
      xfer(1, 0);
      chk_t(t_oe, tv, "read before lock");
      repeat (40) @(negedge clock);
      chk_w({35'h0, pll_locked}, 36'h1, "relock");
   endtask : t_clkstop
   task automatic t_imp();
      realtime t1;
      for (int c = 0; c < 100 && impedance_update !== 1'b1; c++) @(negedge clock);
      t1 = $realtime;
      @(negedge clock);
      for (int c = 0; c < 100 && impedance_update !== 1'b1; c++) @(negedge clock);
      chk_t($realtime - t1, 3200, "impedance period");
   endtask : t_imp
   task automatic t_echo();
      logic [2:0] q;
      logic [2:0] qn;
      for (int i = 0; i < 16; i++) begin
         @(negedge clock);
         if (i >= 3) chk_w({35'h0, echo_timing_true}, {35'h0, q[2]}, "echo true");
         if (i >= 3) chk_w({35'h0, echo_timing_comp}, {35'h0, qn[2]}, "echo comp");
         q = {q[1:0], master_clk};
         qn = {qn[1:0], master_clk_n};
      end
   endtask : t_echo
   initial begin
      repeat (5) @(posedge clock);
      chk_w({35'h0, read_data_oe_n}, 36'h1, "reset drive");
      chk_w({35'h0, read_valid_flag}, 36'h0, "reset valid");
      @(posedge clock) rst <= 1'b0;
      t_lock();
      t_write_read();
      t_bytes();
      t_b2b();
      t_arbit();
      t_forward();
      t_legacy();
      t_clkstop();
      t_imp();
      t_echo();
      finish_test();
   end
endmodule : tb_top
